// ==== verilog/madc_pkg.sv ====
// package: constants and types for the monitor adc scheduler
package madc_pkg;
   localparam int MADC_RES_W = 10;
   localparam int MADC_AUTO_W = 8;
   localparam int MADC_CH_W = 4;
   localparam int MADC_SLOTS = 10;
   localparam int MADC_CLK_MHZ = 100;
   localparam int MADC_SLOT_US = 100;
   localparam int MADC_SLOT_CYC = MADC_SLOT_US * MADC_CLK_MHZ;
   localparam int MADC_FAST_MS = 1;
   localparam int MADC_ECO_MS = 10;
   localparam int MADC_FAST_PER = MADC_FAST_MS * 1000 / MADC_SLOT_US;
   localparam int MADC_ECO_PER = MADC_ECO_MS * 1000 / MADC_SLOT_US;
   localparam int MADC_TJ_GAIN = 3;
   localparam logic [3:0] MADC_CH_SYS = 4'h0;
   localparam logic [3:0] MADC_CH_ICH = 4'h1;
   localparam logic [3:0] MADC_CH_BATTERY_THERMISTOR = 4'h2;
   localparam logic [3:0] MADC_CH_VBAT = 4'h3;
   localparam logic [3:0] MADC_CH_AUXA = 4'h4;
   localparam logic [3:0] MADC_CH_AUXB = 4'h5;
   localparam logic [3:0] MADC_CH_AUXC = 4'h6;
   localparam logic [3:0] MADC_CH_TS = 4'h7;
   localparam logic [3:0] MADC_CH_TJ = 4'h8;
   localparam logic [3:0] MADC_CH_BBAT = 4'h9;
   typedef enum logic [1:0] {
      MADC_IDLE = 2'b00,
      MADC_CONV = 2'b01,
      MADC_TS = 2'b10
   } madc_st_t;
endpackage

// ==== verilog/madc_result_mem.sv ====
// result store: one word per mux channel, registered read
module madc_result_mem
   import madc_pkg::*;
#(
   parameter int DEPTH = MADC_SLOTS,
   parameter int W = MADC_RES_W
) (
   // clock
   input wire logic clk,
   // write side
   input wire logic wr_en,
   input wire logic [MADC_CH_W-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   // read side
   input wire logic [MADC_CH_W-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [DEPTH];

   initial begin
      if (DEPTH > (1 << MADC_CH_W)) $error("depth exceeds address range");
   end

   always_ff @(posedge clk) begin
      if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
      if (int'(rd_addr) < DEPTH) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end
endmodule

// ==== verilog/madc_sched.sv ====
// monitor adc scheduler: slots, manual/auto arbitration, results and events
// Behaviour
// - ten-bit results, ten-way mux selection held stable through each conversion.
// - channels 0..9 map system rail, charger, thermistor, battery, aux a-c, touch, tj, backup.
// - high speed repeats sequence every 1 ms, economy every 10 ms.
// - manual request powers up, converts once, stores 10 bits, powers down, flags.
// - mask blocks the manual-done interrupt but the flag still sets.
// - aux channels checked against upper and lower limits, event when outside.
// - ten slots stepped through and restarted at the mode period.
// - touch enabled splits slot: conversion first half, touch task second half.
// - touch disabled means no split, only the single conversion.
// - each slot lasts 100 us counted on the internal clock.
// - system rail, charger current, battery temperature auto only while charging.
// - auto disabled converts manual at once; else manual uses only free slots, and while charging the system-rail slot stays automatic.
// - auto results store only the upper 8 bits; manual results keep all 10.
// - junction temperature uses channel 8 with sensor gain of three.
// - touch task measures x, y, optional pressure on channel 7, then pen detect.
// - debounce raises aux event only after two consecutive same-side excursions.
module madc_sched
   import madc_pkg::*;
#(
   parameter int SLOT_CYC = MADC_SLOT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire logic auto_en,
   input wire logic fast_mode,
   input wire logic ts_en,
   input wire logic ts_pressure_en,
   input wire logic charging,
   input wire logic [2:0] aux_debounce,
   input wire logic [3*MADC_AUTO_W-1:0] aux_hi,
   input wire logic [3*MADC_AUTO_W-1:0] aux_lo,
   // manual request
   input wire logic man_req,
   input wire logic [MADC_CH_W-1:0] man_ch,
   input wire logic man_irq_mask,
   // event clears, one bit each, written by host
   input wire logic clr_man_done,
   input wire logic [2:0] clr_aux_evt,
   // converter
   output logic adc_pwr,
   output logic adc_start,
   output logic [MADC_CH_W-1:0] adc_mux,
   output logic [1:0] adc_gain,
   input wire logic adc_done,
   input wire logic [MADC_RES_W-1:0] adc_data,
   // touch task
   output logic ts_go,
   output logic ts_pressure,
   // results
   input wire logic [MADC_CH_W-1:0] res_sel,
   output logic [MADC_RES_W-1:0] res_data,
   output logic [MADC_RES_W-1:0] man_result,
   // events and slot index
   output logic man_done,
   output logic man_irq,
   output logic [2:0] aux_evt,
   output logic [3:0] slot_idx
);
   initial begin
      if (SLOT_CYC < 4) $error("slot too short");
   end

   localparam int CW = $clog2(SLOT_CYC + 1);
   localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYC - 1);
   localparam logic [CW-1:0] HALF = CW'(SLOT_CYC / 2);
   localparam logic [6:0] FAST_P = 7'(MADC_FAST_PER);
   localparam logic [6:0] ECO_P = 7'(MADC_ECO_PER);

   madc_st_t st, next_st;
   logic [CW-1:0] cnt, next_cnt;
   logic [6:0] tick, next_tick;
   logic [3:0] slot, next_slot;
   logic man_pend, next_man_pend;
   logic [3:0] man_ch_q, next_man_ch_q;
   logic cur_man, next_cur_man;
   logic [3:0] cur_ch, next_cur_ch;
   logic used_half, next_used_half;
   logic next_adc_pwr, next_adc_start, next_ts_go;
   logic [1:0] next_adc_gain;
   logic [MADC_RES_W-1:0] next_man_result;
   logic next_man_done, next_man_irq;
   logic [2:0] next_aux_evt, hi_prev, next_hi_prev, lo_prev, next_lo_prev;

   // sync converter return
   logic done_s1, done_s2;
   logic [MADC_RES_W-1:0] data_s1, data_s2;
   always_ff @(posedge clk) begin
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      data_s1 <= adc_data;
      data_s2 <= data_s1;
   end
   logic done_q, done_rise;
   always_ff @(posedge clk) begin
      done_q <= rst ? 1'b0 : done_s2;
   end
   assign done_rise = done_s2 && !done_q;

   // fixed slot pattern; auto slot channel or none
   logic auto_hit;
   logic [3:0] auto_ch;
   always_comb begin
      auto_hit = 1'b0;
      auto_ch = MADC_CH_SYS;
      if (auto_en && tick < 7'(MADC_SLOTS)) begin
         case (slot)
            4'h0, 4'h1, 4'h2: begin
               auto_hit = charging;
               auto_ch = slot;
            end
            4'h3: begin
               auto_hit = 1'b1;
               auto_ch = MADC_CH_AUXA;
            end
            4'h4: begin
               auto_hit = 1'b1;
               auto_ch = MADC_CH_AUXB;
            end
            4'h5: begin
               auto_hit = 1'b1;
               auto_ch = MADC_CH_AUXC;
            end
            4'h6: begin
               auto_hit = 1'b1;
               auto_ch = MADC_CH_TJ;
            end
            default: auto_hit = 1'b0;
         endcase
      end
   end

   // store word: auto keeps upper 8 bits
   logic [MADC_RES_W-1:0] store_word;
   logic store_en;
   assign store_word = cur_man ? data_s2 : {data_s2[9:2], 2'b00};
   assign store_en = (st == MADC_CONV) && done_rise;

   madc_result_mem u_mem (
      .clk(clk),
      .wr_en(store_en),
      .wr_addr(cur_ch),
      .wr_data(store_word),
      .rd_addr(res_sel),
      .rd_data(res_data)
   );

   logic slot_end, start_ok;
   assign slot_end = (cnt == SLOT_LAST);
   assign start_ok = !used_half && (cnt < HALF || !ts_en);

   always_comb begin
      next_st = st;
      next_cnt = slot_end ? '0 : cnt + 1'b1;
      next_slot = slot;
      next_tick = tick;
      next_used_half = slot_end ? 1'b0 : used_half;
      next_man_pend = man_pend;
      next_man_ch_q = man_ch_q;
      next_cur_man = cur_man;
      next_cur_ch = cur_ch;
      next_adc_pwr = adc_pwr;
      next_adc_start = 1'b0;
      next_adc_gain = adc_gain;
      next_ts_go = 1'b0;
      next_man_result = man_result;
      if (slot_end) begin
         next_tick = (tick == (fast_mode ? FAST_P : ECO_P) - 7'd1) ? 7'd0 : tick + 7'd1;
         next_slot = (next_tick < 7'(MADC_SLOTS)) ? next_tick[3:0] : slot;
      end
      if (man_req && !man_pend && !man_done && int'(man_ch) < MADC_SLOTS) begin
         next_man_pend = 1'b1;
         next_man_ch_q = man_ch;
      end
      case (st)
         MADC_IDLE: begin
            if (ts_en && cnt == HALF) begin
               next_st = MADC_TS;
               next_ts_go = 1'b1;
            end else if (start_ok && auto_hit && auto_ch != MADC_CH_SYS) begin
               next_st = MADC_CONV;
               next_cur_man = 1'b0;
               next_cur_ch = auto_ch;
               next_used_half = 1'b1;
            end else if (man_pend && (!auto_en || (start_ok && !auto_hit))) begin
               next_st = MADC_CONV;
               next_cur_man = 1'b1;
               next_cur_ch = man_ch_q;
               next_man_pend = 1'b0;
               next_used_half = auto_en;
            end else if (start_ok && auto_hit) begin
               next_st = MADC_CONV;
               next_cur_man = 1'b0;
               next_cur_ch = auto_ch;
               next_used_half = 1'b1;
            end
            if (next_st == MADC_CONV) begin
               next_adc_pwr = 1'b1;
               next_adc_start = 1'b1;
               next_adc_gain = (next_cur_ch == MADC_CH_TJ) ? 2'(MADC_TJ_GAIN) : 2'd1;
            end
         end
         MADC_CONV: begin
            if (done_rise) begin
               next_st = MADC_IDLE;
               next_adc_pwr = 1'b0;
               if (cur_man) next_man_result = data_s2;
            end
         end
         MADC_TS: begin
            if (slot_end) next_st = MADC_IDLE;
         end
         default: next_st = MADC_IDLE;
      endcase
   end

   // events and aux limit checks
   logic [2:0] aux_idx_hit;
   logic [MADC_AUTO_W-1:0] hi_lim, lo_lim;
   logic above, below;
   int ai;
   always_comb begin
      aux_idx_hit = '0;
      ai = int'(cur_ch) - int'(MADC_CH_AUXA);
      hi_lim = '0;
      lo_lim = '0;
      if (store_en && !cur_man && cur_ch >= MADC_CH_AUXA && cur_ch <= MADC_CH_AUXC) begin
         aux_idx_hit[ai] = 1'b1;
         hi_lim = aux_hi[ai*MADC_AUTO_W +: MADC_AUTO_W];
         lo_lim = aux_lo[ai*MADC_AUTO_W +: MADC_AUTO_W];
      end
      above = data_s2[9:2] > hi_lim;
      below = data_s2[9:2] < lo_lim;
      next_man_done = man_done && !clr_man_done;
      if (store_en && cur_man) next_man_done = 1'b1;
      next_man_irq = next_man_done && !man_irq_mask;
      next_hi_prev = hi_prev;
      next_lo_prev = lo_prev;
      next_aux_evt = aux_evt & ~clr_aux_evt;
      for (int i = 0; i < 3; i++) begin
         if (aux_idx_hit[i]) begin
            next_hi_prev[i] = above;
            next_lo_prev[i] = below;
            if ((above && (!aux_debounce[i] || hi_prev[i])) ||
                (below && (!aux_debounce[i] || lo_prev[i]))) begin
               next_aux_evt[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= MADC_IDLE;
         cnt <= '0;
         tick <= '0;
         slot <= '0;
         man_pend <= 1'b0;
         man_ch_q <= '0;
         cur_man <= 1'b0;
         cur_ch <= '0;
         used_half <= 1'b0;
         adc_pwr <= 1'b0;
         adc_start <= 1'b0;
         adc_gain <= 2'd1;
         ts_go <= 1'b0;
         man_result <= '0;
         man_done <= 1'b0;
         man_irq <= 1'b0;
         aux_evt <= '0;
         hi_prev <= '0;
         lo_prev <= '0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         tick <= next_tick;
         slot <= next_slot;
         man_pend <= next_man_pend;
         man_ch_q <= next_man_ch_q;
         cur_man <= next_cur_man;
         cur_ch <= next_cur_ch;
         used_half <= next_used_half;
         adc_pwr <= next_adc_pwr;
         adc_start <= next_adc_start;
         adc_gain <= next_adc_gain;
         ts_go <= next_ts_go;
         man_result <= next_man_result;
         man_done <= next_man_done;
         man_irq <= next_man_irq;
         aux_evt <= next_aux_evt;
         hi_prev <= next_hi_prev;
         lo_prev <= next_lo_prev;
      end
   end

   // mux held at the converting channel for the whole conversion
   always_ff @(posedge clk) begin
      adc_mux <= rst ? '0 : next_cur_ch;
      ts_pressure <= rst ? 1'b0 : ts_pressure_en;
      slot_idx <= rst ? '0 : slot;
   end

   // checks
   mux_stable_a: assert property (@(posedge clk) disable iff (rst)
      st == MADC_CONV && $past(st) == MADC_CONV |-> $stable(adc_mux))
      else $error("mux moved during conversion");
   irq_mask_a: assert property (@(posedge clk) disable iff (rst)
      man_irq |-> man_done && !$past(man_irq_mask))
      else $error("masked manual irq raised");
   one_conv_a: assert property (@(posedge clk) disable iff (rst)
      adc_start |-> $past(st) == MADC_IDLE && st == MADC_CONV)
      else $error("start while converting");
   no_split_a: assert property (@(posedge clk) disable iff (rst)
      !ts_en && !$past(ts_en) |-> !ts_go)
      else $error("touch task with touch disabled");
   slot_len_a: assert property (@(posedge clk) disable iff (rst)
      cnt == SLOT_LAST |=> cnt == '0)
      else $error("slot length wrong");
   flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      man_done && !clr_man_done |=> man_done)
      else $error("manual flag dropped");
   no_man_pend_a: assert property (@(posedge clk) disable iff (rst)
      $rose(man_pend) |-> !$past(man_done))
      else $error("manual accepted with flag set");
   tj_gain_a: assert property (@(posedge clk) disable iff (rst)
      adc_start && adc_mux == MADC_CH_TJ |-> adc_gain == 2'd3)
      else $error("tj gain wrong");
   pwr_down_a: assert property (@(posedge clk) disable iff (rst)
      $rose(man_done) |-> !adc_pwr)
      else $error("flag before power down");
   man_cov: cover property (@(posedge clk) $rose(man_done));
   aux_cov: cover property (@(posedge clk) $rose(aux_evt[0]));
   ts_cov: cover property (@(posedge clk) ts_go);
   wrap_cov: cover property (@(posedge clk) slot_end && tick == 7'd0);
endmodule

// ==== tb/madc_adc_model.sv ====
// converter stand-in: answers each start after a set delay with a channel code
module madc_adc_model
   import madc_pkg::*;
(
   // clock and control
   input wire logic clk,
   input wire logic adc_start,
   input wire logic [MADC_CH_W-1:0] adc_mux,
   input wire logic [7:0] conv_cyc,
   // answer
   output logic adc_done,
   output logic [MADC_RES_W-1:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   always @(posedge clk) begin
      if (adc_start === 1'b1) begin
         cnt <= int'(conv_cyc) + 8;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   // code follows the live mux, so a mux moved mid-conversion corrupts the result
   assign adc_done = (cnt > 0) && (cnt <= 5);
   assign adc_data = (cnt > 0 && cnt <= 8) ? {adc_mux, 6'h2b} : ~{adc_mux, 6'h2b};
endmodule

// ==== tb/monitor_adc_scheduler_tb.sv ====
// self-checking bench: manual, masked, automatic, touch and economy runs
module monitor_adc_scheduler_tb;
   import madc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 40;
   logic clk = 0;
   logic rst = 1;
   logic auto_en = 0;
   logic fast_mode = 1;
   logic ts_en = 0;
   logic ts_pressure_en = 0;
   logic charging = 0;
   logic [2:0] aux_debounce = 3'h0;
   logic [23:0] aux_hi = 24'hff_ff40;
   logic [23:0] aux_lo = 24'h70_0000;
   logic man_req = 0;
   logic [3:0] man_ch = 4'h0;
   logic man_irq_mask = 0;
   logic clr_man_done = 0;
   logic [2:0] clr_aux_evt = 3'h0;
   logic [3:0] res_sel = 4'h0;
   logic [7:0] conv_cyc = 8'h0c;
   logic adc_pwr, adc_start, adc_done, ts_go, ts_pressure, man_done, man_irq;
   logic [3:0] adc_mux, slot_idx, last_mux, prev_mux, prev_slot;
   logic [1:0] adc_gain;
   logic [9:0] adc_data, res_data, man_result;
   logic [2:0] aux_evt;
   logic [5:0] starts[$];
   int num_errors = 0;
   int comparisons = 0;
   int n_start = 0;
   int n_ts = 0;
   int cyc = 0;
   int last_tj = 0;
   int tj_gap = 0;
   int last_slot = 0;
   int slot_len = 0;
   madc_sched #(.SLOT_CYC(SC)) madc_sched_inst (.clk(clk), .rst(rst), .auto_en(auto_en),
      .fast_mode(fast_mode), .ts_en(ts_en), .ts_pressure_en(ts_pressure_en),
      .charging(charging), .aux_debounce(aux_debounce), .aux_hi(aux_hi), .aux_lo(aux_lo),
      .man_req(man_req), .man_ch(man_ch), .man_irq_mask(man_irq_mask),
      .clr_man_done(clr_man_done), .clr_aux_evt(clr_aux_evt), .adc_pwr(adc_pwr),
      .adc_start(adc_start), .adc_mux(adc_mux), .adc_gain(adc_gain), .adc_done(adc_done),
      .adc_data(adc_data), .ts_go(ts_go), .ts_pressure(ts_pressure), .res_sel(res_sel),
      .res_data(res_data), .man_result(man_result), .man_done(man_done), .man_irq(man_irq),
      .aux_evt(aux_evt), .slot_idx(slot_idx));
   madc_adc_model madc_adc_model_inst (.clk(clk), .adc_start(adc_start), .adc_mux(adc_mux),
      .conv_cyc(conv_cyc), .adc_done(adc_done), .adc_data(adc_data));
   always #5 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // negedge sampling keeps the counters clear of the launching edge
   always @(negedge clk) begin
      cyc++;
      if (adc_start === 1'b1) begin
         n_start++;
         last_mux = adc_mux;
         starts.push_back({adc_gain, adc_mux});
         if (adc_mux === MADC_CH_TJ) begin
            tj_gap = cyc - last_tj;
            last_tj = cyc;
         end
      end else if (adc_pwr === 1'b1) begin
         chk(16'(adc_mux), 16'(prev_mux));
      end
      if (ts_go === 1'b1) n_ts++;
      if (slot_idx !== prev_slot) begin
         slot_len = cyc - last_slot;
         last_slot = cyc;
      end
      prev_mux = adc_mux;
      prev_slot = slot_idx;
   end
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic manual(input logic [3:0] ch);
      man_ch <= ch;
      man_req <= 1'b1;
      @(posedge clk);
      man_req <= 1'b0;
   endtask
   task automatic wait_man();
      int i;
      for (i = 0; i < 600 && man_done !== 1'b1; i++) @(posedge clk);
      if (man_done !== 1'b1) begin
         num_errors++;
         stop_test();
      end
      @(posedge clk);
   endtask
   task automatic clear(input logic m, input logic [2:0] a);
      clr_man_done <= m;
      clr_aux_evt <= a;
      @(posedge clk);
      clr_man_done <= 1'b0;
      clr_aux_evt <= 3'h0;
      cycles(3);
   endtask
   task automatic t_manual();
      int s;
      s = n_start;
      manual(MADC_CH_BBAT);
      wait_man();
      chk(16'(man_result), 16'h026b);
      chk(16'(n_start - s), 16'h0001);
      chk(16'(adc_pwr), 16'h0000);
      chk(16'(man_irq), 16'h0001);
      chk(16'(last_mux), 16'h0009);
      res_sel <= MADC_CH_BBAT;
      cycles(3);
      chk(16'(res_data), 16'h026b);
      manual(MADC_CH_VBAT);
      cycles(60);
      chk(16'(n_start - s), 16'h0001);
      chk(16'(man_result), 16'h026b);
      chk(16'(man_done), 16'h0001);
      clear(1'b1, 3'h0);
      chk(16'({man_done, man_irq}), 16'h0000);
   endtask
   task automatic t_mask();
      man_irq_mask <= 1'b1;
      conv_cyc <= 8'h02;
      manual(MADC_CH_VBAT);
      wait_man();
      chk(16'({man_done, man_irq}), 16'h0002);
      chk(16'(man_result), 16'h00eb);
      clear(1'b1, 3'h0);
      man_irq_mask <= 1'b0;
   endtask
   function automatic logic [15:0] seen_mask();
      logic [15:0] m;
      m = 16'h0000;
      foreach (starts[i]) m[starts[i][3:0]] = 1'b1;
      return m;
   endfunction
   task automatic t_auto();
      int bad;
      bad = 0;
      charging <= 1'b1;
      auto_en <= 1'b1;
      starts.delete();
      cycles(3 * MADC_FAST_PER * SC);
      foreach (starts[i]) begin
         if (starts[i][5:4] !== ((starts[i][3:0] == MADC_CH_TJ) ? 2'h3 : 2'h1)) bad++;
      end
      chk(seen_mask(), 16'h0177);
      chk(16'(bad), 16'h0000);
      chk(16'(tj_gap), 16'(MADC_FAST_PER * SC));
      chk(16'(slot_len), 16'(SC));
      chk(16'(aux_evt), 16'h0005);
      res_sel <= MADC_CH_ICH;
      cycles(3);
      chk(16'(res_data), 16'h0068);
      manual(MADC_CH_BBAT);
      wait_man();
      chk(16'(man_result), 16'h026b);
      clear(1'b1, 3'h0);
   endtask
   // starts in slot 7 so each window holds exactly one aux a store, far from its ends
   task automatic t_aux();
      int i;
      for (i = 0; i < 500 && slot_idx !== 4'h7; i++) @(posedge clk);
      if (slot_idx !== 4'h7) begin
         num_errors++;
         stop_test();
      end
      aux_hi <= 24'hff_ffff;
      aux_lo <= 24'h00_0000;
      cycles(MADC_FAST_PER * SC);
      chk(16'(aux_evt), 16'h0005);
      clear(1'b0, 3'h7);
      chk(16'(aux_evt), 16'h0000);
      aux_debounce <= 3'h1;
      aux_hi <= 24'hff_ff40;
      cycles(MADC_FAST_PER * SC);
      chk(16'(aux_evt), 16'h0000);
      cycles(MADC_FAST_PER * SC);
      chk(16'(aux_evt), 16'h0001);
      aux_debounce <= 3'h0;
      clear(1'b0, 3'h7);
   endtask
   task automatic t_touch();
      ts_pressure_en <= 1'b1;
      ts_en <= 1'b1;
      cycles(SC);
      n_ts = 0;
      cycles(MADC_FAST_PER * SC);
      chk(16'(n_ts), 16'(MADC_SLOTS));
      chk(16'(ts_pressure), 16'h0001);
      ts_en <= 1'b0;
      cycles(SC);
      n_ts = 0;
      cycles(MADC_FAST_PER * SC);
      chk(16'(n_ts), 16'h0000);
   endtask
   task automatic t_eco();
      charging <= 1'b0;
      fast_mode <= 1'b0;
      cycles(MADC_ECO_PER * SC);
      starts.delete();
      cycles(2 * MADC_ECO_PER * SC);
      chk(seen_mask() & 16'h0007, 16'h0000);
      chk(16'(tj_gap), 16'(MADC_ECO_PER * SC));
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      cycles(2);
      chk(16'({adc_pwr, man_done, man_irq, aux_evt}), 16'h0000);
      t_manual();
      t_mask();
      t_auto();
      t_aux();
      t_touch();
      t_eco();
      stop_test();
   end
endmodule
